// ---- pkg/osc_pkg.sv ----
// constants, types and offsets shared by the oscillator control register bank
// ============================================================================
// Summary of operation
// - vendor code, high byte 0, low 1
// - fixed product code byte at offset 2
// - fixed mask revision byte at offset 3
// - target address in bits 7:1, answered
// - address pin sets bits 2:1 after reset pin or software reset, power-on loads the low code
// - image revision reloaded on reset and commit
// - after reset PLL follows power-down bit
// - power-down stops PLL, clearing restarts calibration
// - trigger bit rising starts calibration, self-clears
// - automatic start locks PLL, then enables outputs
// - power-on, reset pin, software reset equivalent, except power-on reads the address pin as low and software reset does not reset the i2c engine
// - without automatic start, wait for host trigger
package osc_pkg;

    // ========================================================================
    // register offsets
    localparam logic [7:0] OFS_VENDOR_HI  = 8'h00;
    localparam logic [7:0] OFS_VENDOR_LO  = 8'h01;
    localparam logic [7:0] OFS_PRODUCT    = 8'h02;
    localparam logic [7:0] OFS_MASK_REV   = 8'h03;
    localparam logic [7:0] OFS_TARGET     = 8'h08;
    localparam logic [7:0] OFS_IMAGE_REV  = 8'h09;
    localparam logic [7:0] OFS_CONTROL    = 8'h0A;
    localparam logic [7:0] OFS_SOFT_RESET = 8'h48;

    // ========================================================================
    // device control fields
    localparam int         CTL_PDN_BIT   = 6;
    localparam int         CTL_SEL_BIT   = 5;
    localparam int         CTL_CAL_BIT   = 1;
    localparam int         CTL_AUTO_BIT  = 0;
    localparam logic [7:0] CTL_RW_MASK   = 8'h61;
    localparam logic [7:0] CTL_RESET     = 8'h21;

    // ========================================================================
    // address register fields and reset values
    localparam logic [7:0] TARGET_RESET  = 8'h58;
    localparam logic [7:0] IMGREV_RESET  = 8'h00;
    localparam logic [1:0] PIN_LOW_CODE  = 2'h0;
    localparam logic [1:0] PIN_FLT_CODE  = 2'h1;
    localparam logic [1:0] PIN_HIGH_CODE = 2'h3;

    // ========================================================================
    // timing
    localparam int CLK_FREQ_MHZ = 200;
    localparam int CAL_TIME_NS  = 10000;
    localparam int CAL_CYCLES   = (CAL_TIME_NS * CLK_FREQ_MHZ) / 1000;
    localparam int BYTE_BITS    = 8;

    // ========================================================================
    // state types
    typedef enum logic [2:0] {
        I2C_IDLE,
        I2C_ADDR,
        I2C_RX,
        I2C_ACK,
        I2C_TX,
        I2C_MACK
    } osc_i2c_st_t;

    typedef enum logic [1:0] {
        SEQ_OFF,
        SEQ_IDLE,
        SEQ_CAL,
        SEQ_LOCK
    } osc_seq_st_t;

endpackage : osc_pkg

// ---- pkg/osc_cal_if.sv ----
// control and status between register bank and pll calibration sequencer
`timescale 1ns/1ps
interface osc_cal_if;
    logic power_down;
    logic start;
    logic pll_enable;
    logic calibrating;
    logic locked;
    logic done;

    modport ctl (
        output power_down,
        output start,
        input  pll_enable,
        input  calibrating,
        input  locked,
        input  done
    );

    modport seq (
        input  power_down,
        input  start,
        output pll_enable,
        output calibrating,
        output locked,
        output done
    );
endinterface : osc_cal_if

// ---- verilog/osc_cal_seq.sv ----
// pll enable and calibration sequencer
`timescale 1ns/1ps
module osc_cal_seq #(
    parameter int CAL_CYCLES = osc_pkg::CAL_CYCLES
) (
    input  logic   clk,
    input  logic   rst,
    osc_cal_if.seq cal
);
    localparam int CW = $clog2(CAL_CYCLES + 1);

    if (CAL_CYCLES < 1) begin : g_chk
        $error("CAL_CYCLES must be at least one");
    end

    osc_pkg::osc_seq_st_t st_ff;
    osc_pkg::osc_seq_st_t nxt_st;
    logic [CW-1:0]        cnt_ff;
    logic [CW-1:0]        nxt_cnt;
    logic                 done_ff;
    logic                 nxt_done;

    // ========================================================================
    // next state
    always_comb begin
        nxt_st   = st_ff;
        nxt_cnt  = cnt_ff;
        nxt_done = 1'b0;
        // power-down wins
        if (cal.power_down) begin
            nxt_st = osc_pkg::SEQ_OFF;
        end else begin
            unique case (st_ff)
                osc_pkg::SEQ_OFF: begin
                    nxt_st = cal.start ? osc_pkg::SEQ_CAL : osc_pkg::SEQ_IDLE;
                end
                osc_pkg::SEQ_IDLE, osc_pkg::SEQ_LOCK: begin
                    if (cal.start) begin
                        nxt_st = osc_pkg::SEQ_CAL;
                    end
                end
                osc_pkg::SEQ_CAL: begin
                    if (cnt_ff == CW'(CAL_CYCLES - 1)) begin
                        nxt_st   = osc_pkg::SEQ_LOCK;
                        nxt_done = 1'b1;
                    end
                end
            endcase
        end
        if (nxt_st == osc_pkg::SEQ_CAL && (st_ff != osc_pkg::SEQ_CAL || cal.start)) begin
            nxt_cnt = '0;
        end else if (st_ff == osc_pkg::SEQ_CAL) begin
            nxt_cnt = cnt_ff + CW'(1);
        end
    end

    // ========================================================================
    // registers
    always_ff @(posedge clk) begin
        if (rst) begin
            st_ff   <= osc_pkg::SEQ_OFF;
            cnt_ff  <= '0;
            done_ff <= 1'b0;
        end else begin
            st_ff   <= nxt_st;
            cnt_ff  <= nxt_cnt;
            done_ff <= nxt_done;
        end
    end

    assign cal.pll_enable  = (st_ff != osc_pkg::SEQ_OFF);
    assign cal.calibrating = (st_ff == osc_pkg::SEQ_CAL);
    assign cal.locked      = (st_ff == osc_pkg::SEQ_LOCK);
    assign cal.done        = done_ff;
endmodule : osc_cal_seq

// ---- verilog/osc_regs.sv ----
// oscillator identification and device control register bank with i2c target
`timescale 1ns/1ps
module osc_regs #(
    parameter logic [15:0] VENDOR_CODE  = 16'h5AD1, // arbitrary value
    parameter logic [7:0]  PRODUCT_CODE = 8'h6C,    // arbitrary value
    parameter logic [7:0]  MASK_REV     = 8'h01,    // arbitrary value
    parameter int          CAL_CYCLES   = osc_pkg::CAL_CYCLES
) (
    input  logic       clk,
    input  logic       sys_rst,
    input  logic       reset_pin_n,
    input  logic       addr_pin_high,
    input  logic       addr_pin_float,
    input  logic       scl_in,
    input  logic       sda_in,
    output logic       sda_out,
    output logic       sda_oe,
    input  logic [6:0] nvm_target_address,
    input  logic [7:0] nvm_image_revision,
    input  logic [7:0] nvm_control,
    input  logic       nvm_commit_done,
    output logic       pll_enable,
    output logic       pll_calibrating,
    output logic       pll_locked,
    output logic       output_enable
);
    localparam int PDN  = osc_pkg::CTL_PDN_BIT;
    localparam int CALB = osc_pkg::CTL_CAL_BIT;
    localparam int AUTO = osc_pkg::CTL_AUTO_BIT;

    // ========================================================================
    // input synchronisers
    logic scl_s1_ff;
    logic scl_s2_ff;
    logic scl_d_ff;
    logic sda_s1_ff;
    logic sda_s2_ff;
    logic sda_d_ff;
    logic rpin_s1_ff;
    logic rpin_s2_ff;
    logic ahi_s1_ff;
    logic ahi_s2_ff;
    logic aflt_s1_ff;
    logic aflt_s2_ff;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            scl_s1_ff  <= 1'b1;
            scl_s2_ff  <= 1'b1;
            scl_d_ff   <= 1'b1;
            sda_s1_ff  <= 1'b1;
            sda_s2_ff  <= 1'b1;
            sda_d_ff   <= 1'b1;
            rpin_s1_ff <= 1'b1;
            rpin_s2_ff <= 1'b1;
            ahi_s1_ff  <= 1'b0;
            ahi_s2_ff  <= 1'b0;
            aflt_s1_ff <= 1'b0;
            aflt_s2_ff <= 1'b0;
        end else begin
            scl_s1_ff  <= scl_in;
            scl_s2_ff  <= scl_s1_ff;
            scl_d_ff   <= scl_s2_ff;
            sda_s1_ff  <= sda_in;
            sda_s2_ff  <= sda_s1_ff;
            sda_d_ff   <= sda_s2_ff;
            rpin_s1_ff <= reset_pin_n;
            rpin_s2_ff <= rpin_s1_ff;
            ahi_s1_ff  <= addr_pin_high;
            ahi_s2_ff  <= ahi_s1_ff;
            aflt_s1_ff <= addr_pin_float;
            aflt_s2_ff <= aflt_s1_ff;
        end
    end

    logic scl_rise;
    logic scl_fall;
    logic bus_start;
    logic bus_stop;

    assign scl_rise  = scl_s2_ff & ~scl_d_ff;
    assign scl_fall  = ~scl_s2_ff & scl_d_ff;
    assign bus_start = scl_s2_ff & scl_d_ff & sda_d_ff & ~sda_s2_ff;
    assign bus_stop  = scl_s2_ff & scl_d_ff & ~sda_d_ff & sda_s2_ff;

    // ========================================================================
    // register state
    logic [7:0] target_ff;
    logic [7:0] nxt_target;
    logic [7:0] imgrev_ff;
    logic [7:0] nxt_imgrev;
    logic [7:0] ctl_ff;
    logic [7:0] nxt_ctl;
    logic       dev_rst_ff;
    logic       nxt_dev_rst;
    logic       boot_ff;
    logic       launch_ff;
    logic       run_ff;
    logic       nxt_run;
    logic       out_en_ff;
    logic       nxt_out_en;
    logic       start_ff;
    logic       nxt_start;
    logic       reg_rst;
    logic       wr_en;
    logic [7:0] rd_byte;
    logic [1:0] pin_code;

    // ========================================================================
    // i2c target engine state
    osc_pkg::osc_i2c_st_t st_ff;
    osc_pkg::osc_i2c_st_t nxt_st;
    logic [3:0]           cnt_ff;
    logic [3:0]           nxt_cnt;
    logic [7:0]           shift_ff;
    logic [7:0]           nxt_shift;
    logic [7:0]           ptr_ff;
    logic [7:0]           nxt_ptr;
    logic                 rw_ff;
    logic                 nxt_rw;
    logic                 ptr_set_ff;
    logic                 nxt_ptr_set;
    logic                 oe_ff;
    logic                 nxt_oe;

    osc_cal_if cal ();

    osc_cal_seq #(
        .CAL_CYCLES (CAL_CYCLES)
    ) u_seq (
        .clk (clk),
        .rst (reg_rst),
        .cal (cal)
    );

    assign reg_rst = sys_rst | dev_rst_ff;

    // ========================================================================
    // read data
    always_comb begin
        unique case (ptr_ff)
            // vendor code bytes
            // vendor code split
            osc_pkg::OFS_VENDOR_HI: rd_byte = VENDOR_CODE[15:8];
            osc_pkg::OFS_VENDOR_LO: rd_byte = VENDOR_CODE[7:0];
            osc_pkg::OFS_PRODUCT:   rd_byte = PRODUCT_CODE;
            osc_pkg::OFS_MASK_REV:  rd_byte = MASK_REV;
            osc_pkg::OFS_TARGET:    rd_byte = target_ff;
            osc_pkg::OFS_IMAGE_REV: rd_byte = imgrev_ff;
            osc_pkg::OFS_CONTROL:   rd_byte = ctl_ff & (osc_pkg::CTL_RW_MASK | 8'h02);
            default:                rd_byte = 8'h00;
        endcase
    end

    // ========================================================================
    // i2c target next state
    always_comb begin
        nxt_st      = st_ff;
        nxt_cnt     = cnt_ff;
        nxt_shift   = shift_ff;
        nxt_ptr     = ptr_ff;
        nxt_rw      = rw_ff;
        nxt_ptr_set = ptr_set_ff;
        nxt_oe      = oe_ff;
        wr_en       = 1'b0;
        if (bus_stop) begin
            nxt_st = osc_pkg::I2C_IDLE;
            nxt_oe = 1'b0;
        end else if (bus_start) begin
            nxt_st      = osc_pkg::I2C_ADDR;
            nxt_cnt     = 4'h0;
            nxt_oe      = 1'b0;
            nxt_ptr_set = 1'b0;
        end else begin
            unique case (st_ff)
                osc_pkg::I2C_IDLE: begin
                    nxt_oe = 1'b0;
                end
                osc_pkg::I2C_ADDR, osc_pkg::I2C_RX: begin
                    if (scl_rise && cnt_ff != 4'h8) begin
                        nxt_shift = {shift_ff[6:0], sda_s2_ff};
                        nxt_cnt   = cnt_ff + 4'h1;
                    end else if (scl_fall && cnt_ff == 4'h8) begin
                        if (st_ff == osc_pkg::I2C_ADDR) begin
                            if (shift_ff[7:1] == target_ff[7:1]) begin
                                nxt_rw = shift_ff[0];
                                nxt_oe = 1'b1;
                                nxt_st = osc_pkg::I2C_ACK;
                            end else begin
                                nxt_st = osc_pkg::I2C_IDLE;
                            end
                        end else begin
                            if (!ptr_set_ff) begin
                                nxt_ptr     = shift_ff;
                                nxt_ptr_set = 1'b1;
                            end else begin
                                wr_en   = 1'b1;
                                nxt_ptr = ptr_ff + 8'h01;
                            end
                            nxt_oe = 1'b1;
                            nxt_st = osc_pkg::I2C_ACK;
                        end
                    end
                end
                osc_pkg::I2C_ACK: begin
                    if (scl_fall) begin
                        if (rw_ff) begin
                            nxt_oe    = ~rd_byte[7];
                            nxt_shift = {rd_byte[6:0], 1'b0};
                            nxt_cnt   = 4'h1;
                            nxt_ptr   = ptr_ff + 8'h01;
                            nxt_st    = osc_pkg::I2C_TX;
                        end else begin
                            nxt_oe  = 1'b0;
                            nxt_cnt = 4'h0;
                            nxt_st  = osc_pkg::I2C_RX;
                        end
                    end
                end
                osc_pkg::I2C_TX: begin
                    if (scl_fall) begin
                        if (cnt_ff == 4'h8) begin
                            nxt_oe = 1'b0;
                            nxt_st = osc_pkg::I2C_MACK;
                        end else begin
                            nxt_oe    = ~shift_ff[7];
                            nxt_shift = {shift_ff[6:0], 1'b0};
                            nxt_cnt   = cnt_ff + 4'h1;
                        end
                    end
                end
                osc_pkg::I2C_MACK: begin
                    if (scl_rise) begin
                        nxt_st = sda_s2_ff ? osc_pkg::I2C_IDLE : osc_pkg::I2C_ACK;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst || !rpin_s2_ff) begin
            st_ff      <= osc_pkg::I2C_IDLE;
            cnt_ff     <= 4'h0;
            shift_ff   <= 8'h00;
            ptr_ff     <= 8'h00;
            rw_ff      <= 1'b0;
            ptr_set_ff <= 1'b0;
            oe_ff      <= 1'b0;
        end else begin
            st_ff      <= nxt_st;
            cnt_ff     <= nxt_cnt;
            shift_ff   <= nxt_shift;
            ptr_ff     <= nxt_ptr;
            rw_ff      <= nxt_rw;
            ptr_set_ff <= nxt_ptr_set;
            oe_ff      <= nxt_oe;
        end
    end

    // ========================================================================
    // register bank next state
    always_comb begin
        pin_code = ahi_s2_ff  ? osc_pkg::PIN_HIGH_CODE :
                   aflt_s2_ff ? osc_pkg::PIN_FLT_CODE  : osc_pkg::PIN_LOW_CODE;
        nxt_target = target_ff;
        nxt_imgrev = imgrev_ff;
        nxt_ctl    = ctl_ff;
        nxt_run    = run_ff;
        nxt_start  = 1'b0;
        nxt_dev_rst = ~rpin_s2_ff | (wr_en && ptr_ff == osc_pkg::OFS_SOFT_RESET);
        if (boot_ff) begin
            nxt_target = {nvm_target_address[6:2], pin_code, 1'b0};
            nxt_ctl    = nvm_control & osc_pkg::CTL_RW_MASK;
        end
        if (boot_ff || nvm_commit_done) begin
            nxt_imgrev = nvm_image_revision;
        end
        if (launch_ff && !ctl_ff[PDN] && ctl_ff[AUTO]) begin
            nxt_start = 1'b1;
            nxt_run   = 1'b1;
        end
        if (cal.done) begin
            nxt_ctl[CALB] = 1'b0;
        end
        if (wr_en && ptr_ff == osc_pkg::OFS_CONTROL) begin
            nxt_ctl = (shift_ff & osc_pkg::CTL_RW_MASK) | {6'h00, nxt_ctl[CALB], 1'b0};
            if (ctl_ff[PDN] && !shift_ff[PDN]) begin
                nxt_start = 1'b1;
            end
            if (shift_ff[CALB] && !ctl_ff[CALB] && !shift_ff[PDN]) begin
                nxt_ctl[CALB] = 1'b1;
                nxt_start     = 1'b1;
                nxt_run       = 1'b1;
            end
        end
        if (nxt_ctl[PDN]) begin
            nxt_ctl[CALB] = 1'b0;
        end
        nxt_out_en = run_ff & cal.locked & ~ctl_ff[PDN];
    end

    always_ff @(posedge clk) begin
        if (reg_rst) begin
            target_ff <= osc_pkg::TARGET_RESET;
            imgrev_ff <= osc_pkg::IMGREV_RESET;
            ctl_ff    <= osc_pkg::CTL_RESET;
            run_ff    <= 1'b0;
            out_en_ff <= 1'b0;
            start_ff  <= 1'b0;
            launch_ff <= 1'b0;
        end else begin
            target_ff <= nxt_target;
            imgrev_ff <= nxt_imgrev;
            ctl_ff    <= nxt_ctl;
            run_ff    <= nxt_run;
            out_en_ff <= nxt_out_en;
            start_ff  <= nxt_start;
            launch_ff <= boot_ff;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            dev_rst_ff <= 1'b1;
            boot_ff    <= 1'b0;
        end else begin
            dev_rst_ff <= nxt_dev_rst;
            boot_ff    <= dev_rst_ff;
        end
    end

    assign cal.power_down = ctl_ff[PDN];
    assign cal.start      = start_ff;

    // ========================================================================
    // outputs
    assign sda_out         = 1'b0;
    assign sda_oe          = oe_ff;
    assign pll_enable      = cal.pll_enable;
    assign pll_calibrating = cal.calibrating;
    assign pll_locked      = cal.locked;
    assign output_enable   = out_en_ff;
endmodule : osc_regs

// ---- verification/osc_regs_sva.sv ----
// assertions on the ports of the oscillator register bank
`timescale 1ns/1ps
module osc_regs_sva #(
    parameter int CAL_CYCLES = 16
) (
    input logic       clk,
    input logic       sys_rst,
    input logic       reset_pin_n,
    input logic       addr_pin_high,
    input logic       addr_pin_float,
    input logic       scl_in,
    input logic       sda_in,
    input logic       sda_out,
    input logic       sda_oe,
    input logic [6:0] nvm_target_address,
    input logic [7:0] nvm_image_revision,
    input logic [7:0] nvm_control,
    input logic       nvm_commit_done,
    input logic       pll_enable,
    input logic       pll_calibrating,
    input logic       pll_locked,
    input logic       output_enable
);
    localparam int CAL_MAX = CAL_CYCLES + 8;
    logic [15:0] cal_cnt_ff;
    logic [15:0] nxt_cal_cnt;
    // ==========
    // calibration length counter
    always_comb begin
        nxt_cal_cnt = (sys_rst || !pll_calibrating) ? 16'h0000 : cal_cnt_ff + 16'h0001;
    end
    always_ff @(posedge clk) begin
        cal_cnt_ff <= nxt_cal_cnt;
    end
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    // ==========
    // properties
    sequence s_cal_on;
        $rose(pll_calibrating);
    endsequence
    sequence s_cal_off;
        !pll_calibrating;
    endsequence
    property p_cal_ends;
        s_cal_on |-> ##[1:CAL_MAX] s_cal_off;
    endproperty
    property p_cal_len;
        $fell(pll_calibrating) && pll_locked
            |-> cal_cnt_ff >= CAL_CYCLES - 1 && cal_cnt_ff <= CAL_CYCLES + 1;
    endproperty
    property p_oe_scl_low;
        $changed(sda_oe) |-> !scl_in;
    endproperty
    property p_rst_quiet;
        disable iff (1'b0) sys_rst |=> !pll_enable && !output_enable && !sda_oe;
    endproperty
    property p_pin_rst;
        $fell(reset_pin_n) |-> ##[1:6] !pll_locked && !output_enable;
    endproperty
    property p_lock_pll;
        pll_locked |-> pll_enable;
    endproperty
    property p_cal_excl;
        pll_calibrating |-> pll_enable && !pll_locked;
    endproperty
    property p_out_lock;
        $rose(output_enable) |-> $past(pll_locked);
    endproperty
    property p_lock_after_cal;
        $rose(pll_locked) |-> $past(pll_calibrating);
    endproperty
    a_cal_ends: assert property (p_cal_ends)
        else $error("calibration did not end in time");
    a_cal_len: assert property (p_cal_len)
        else $error("calibration length wrong");
    a_oe_scl_low: assert property (p_oe_scl_low)
        else $error("sda driver changed while scl high");
    a_rst_quiet: assert property (p_rst_quiet)
        else $error("outputs active during reset");
    a_pin_rst: assert property (p_pin_rst)
        else $error("reset pin did not stop pll");
    a_lock_pll: assert property (p_lock_pll)
        else $error("locked while pll off");
    a_cal_excl: assert property (p_cal_excl)
        else $error("calibrating while off or locked");
    a_out_lock: assert property (p_out_lock)
        else $error("outputs enabled before lock");
    a_lock_after_cal: assert property (p_lock_after_cal)
        else $error("lock without calibration");
endmodule : osc_regs_sva

bind osc_regs osc_regs_sva #(.CAL_CYCLES(CAL_CYCLES)) u_sva (.*);

// ---- verification/osc_i2c_host.sv ----
// i2c host model that reaches the register bank over scl and sda
`timescale 1ns/1ps
module osc_i2c_host (
    input  logic clk,
    input  logic sda_oe,
    output logic scl_in,
    output logic sda_in
);
    logic       sda_drv;
    logic [6:0] dev;
    // pull-up: sda high unless a party pulls it low
    assign sda_in = sda_drv & ~sda_oe;
    initial begin
        scl_in = 1'b1;
        sda_drv = 1'b1;
        dev = 7'h2C;
    end
    task automatic q;
        repeat (6) @(posedge clk);
    endtask : q
    task automatic bit_x(input logic b, output logic r);
        q();
        sda_drv <= b;
        q();
        scl_in <= 1'b1;
        q();
        q();
        r = sda_in;
        scl_in <= 1'b0;
    endtask : bit_x
    task automatic start;
        q();
        sda_drv <= 1'b1;
        q();
        scl_in <= 1'b1;
        q();
        sda_drv <= 1'b0;
        q();
        scl_in <= 1'b0;
    endtask : start
    task automatic stop;
        q();
        sda_drv <= 1'b0;
        q();
        scl_in <= 1'b1;
        q();
        sda_drv <= 1'b1;
        q();
    endtask : stop
    task automatic wr_byte(input logic [7:0] d, inout logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_x(d[i], r);
        end
        bit_x(1'b1, r);
        ack = ack & ~r;
    endtask : wr_byte
    task automatic reg_wr(input logic [7:0] ofs, input logic [7:0] d, output logic ack);
        ack = 1'b1;
        start();
        wr_byte({dev, 1'b0}, ack);
        wr_byte(ofs, ack);
        wr_byte(d, ack);
        stop();
    endtask : reg_wr
    task automatic reg_rd(input logic [7:0] ofs, output logic [7:0] d);
        logic a;
        logic r;
        a = 1'b1;
        start();
        wr_byte({dev, 1'b0}, a);
        wr_byte(ofs, a);
        start();
        wr_byte({dev, 1'b1}, a);
        for (int i = 7; i >= 0; i--) begin
            bit_x(1'b1, r);
            d[i] = r;
        end
        bit_x(1'b1, r);
        stop();
    endtask : reg_rd
endmodule : osc_i2c_host

// ---- verification/osc_regs_bench.sv ----
// self-checking bench for the oscillator register bank
`timescale 1ns/1ps
module osc_regs_bench;
    localparam logic [15:0] VEND = 16'h3C7A; // arbitrary value
    localparam logic [7:0]  PROD = 8'h9E;    // arbitrary value
    localparam logic [7:0]  MREV = 8'h05;    // arbitrary value
    logic       clk = 1'b0;
    logic       sys_rst, reset_pin_n, pin_high, pin_float, commit;
    logic       scl_in, sda_in, sda_oe;
    logic [6:0] nvm_tgt;
    logic [7:0] nvm_img, nvm_ctl;
    logic       pll_enable, pll_calibrating, pll_locked, output_enable;
    int         error_cnt = 0;
    int         n_checks = 0;
    int         cyc = 0;
    always #2.5 clk = ~clk;
    osc_regs #(.VENDOR_CODE(VEND), .PRODUCT_CODE(PROD), .MASK_REV(MREV), .CAL_CYCLES(16)) dut (
        .clk(clk), .sys_rst(sys_rst), .reset_pin_n(reset_pin_n),
        .addr_pin_high(pin_high), .addr_pin_float(pin_float),
        .scl_in(scl_in), .sda_in(sda_in), .sda_out(), .sda_oe(sda_oe),
        .nvm_target_address(nvm_tgt), .nvm_image_revision(nvm_img),
        .nvm_control(nvm_ctl), .nvm_commit_done(commit), .pll_enable(pll_enable),
        .pll_calibrating(pll_calibrating), .pll_locked(pll_locked),
        .output_enable(output_enable)
    );
    osc_i2c_host host (.clk(clk), .sda_oe(sda_oe), .scl_in(scl_in), .sda_in(sda_in));
    // ==========
    // access and compare tasks
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic rd(input logic [7:0] ofs, input logic [7:0] exp);
        logic [7:0] d;
        host.reg_rd(ofs, d);
        chk($sformatf("register %h", ofs), exp, d);
    endtask : rd
    task automatic wr(input logic [7:0] ofs, input logic [7:0] d, input logic ack_exp);
        logic a;
        host.reg_wr(ofs, d, a);
        chk("write ack", {7'h00, ack_exp}, {7'h00, a});
    endtask : wr
    // pll status as enable, locked, output enable
    task automatic st(input logic [2:0] exp);
        chk("pll status", {5'h00, exp}, {5'h00, pll_enable, pll_locked, output_enable});
    endtask : st
    task automatic tend(input string name);
        $display("test %s done", name);
    endtask : tend
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : tally_and_finish
    always @(posedge clk) begin
        cyc++;
        if (cyc == 60000) begin
            error_cnt++;
            tally_and_finish();
        end
    end
    // ==========
    // test sequence
    initial begin
        sys_rst <= 1'b1;
        reset_pin_n <= 1'b1;
        pin_high <= 1'b0;
        pin_float <= 1'b0;
        commit <= 1'b0;
        nvm_tgt <= 7'h2C;
        nvm_img <= 8'h3A;
        nvm_ctl <= 8'h20;
        repeat (16) @(posedge clk);
        sys_rst <= 1'b0;
        repeat (8) @(posedge clk);
        rd(osc_pkg::OFS_VENDOR_HI, VEND[15:8]);
        rd(osc_pkg::OFS_VENDOR_LO, VEND[7:0]);
        rd(osc_pkg::OFS_PRODUCT, PROD);
        rd(osc_pkg::OFS_MASK_REV, MREV);
        rd(osc_pkg::OFS_TARGET, 8'h58);
        rd(osc_pkg::OFS_IMAGE_REV, 8'h3A);
        rd(osc_pkg::OFS_CONTROL, 8'h20);
        rd(8'h05, 8'h00);
        st(3'h4);
        tend("identity");
        wr(osc_pkg::OFS_VENDOR_HI, 8'hFF, 1'b1);
        wr(osc_pkg::OFS_TARGET, 8'hFF, 1'b1);
        wr(osc_pkg::OFS_CONTROL, 8'hBC, 1'b1);
        rd(osc_pkg::OFS_VENDOR_HI, VEND[15:8]);
        rd(osc_pkg::OFS_TARGET, 8'h58);
        rd(osc_pkg::OFS_CONTROL, 8'h20);
        tend("read only");
        wr(osc_pkg::OFS_CONTROL, 8'h22, 1'b1);
        st(3'h7);
        rd(osc_pkg::OFS_CONTROL, 8'h20);
        wr(osc_pkg::OFS_CONTROL, 8'h60, 1'b1);
        st(3'h0);
        rd(osc_pkg::OFS_CONTROL, 8'h60);
        wr(osc_pkg::OFS_CONTROL, 8'h20, 1'b1);
        chk("pll locked", 8'h01, {7'h00, pll_locked});
        tend("calibration");
        nvm_img <= 8'hC5;
        rd(osc_pkg::OFS_IMAGE_REV, 8'h3A);
        commit <= 1'b1;
        @(posedge clk);
        commit <= 1'b0;
        rd(osc_pkg::OFS_IMAGE_REV, 8'hC5);
        tend("commit");
        nvm_ctl <= 8'h21;
        nvm_img <= 8'h4B;
        pin_float <= 1'b1;
        wr(osc_pkg::OFS_SOFT_RESET, 8'h00, 1'b1);
        host.dev = 7'h2D;
        st(3'h7);
        rd(osc_pkg::OFS_TARGET, 8'h5A);
        rd(osc_pkg::OFS_IMAGE_REV, 8'h4B);
        rd(osc_pkg::OFS_CONTROL, 8'h21);
        tend("software reset");
        nvm_ctl <= 8'h61;
        nvm_tgt <= 7'h6E;
        pin_float <= 1'b0;
        pin_high <= 1'b1;
        reset_pin_n <= 1'b0;
        repeat (8) @(posedge clk);
        reset_pin_n <= 1'b1;
        repeat (40) @(posedge clk);
        st(3'h0);
        wr(osc_pkg::OFS_CONTROL, 8'h20, 1'b0);
        host.dev = 7'h6F;
        rd(osc_pkg::OFS_TARGET, 8'hDE);
        rd(osc_pkg::OFS_CONTROL, 8'h61);
        wr(osc_pkg::OFS_CONTROL, 8'h21, 1'b1);
        chk("pll locked", 8'h01, {7'h00, pll_locked});
        tend("reset pin");
        tally_and_finish();
    end
endmodule : osc_regs_bench
